/* rtl/fpx_params.svh */
// Constants for the floating-point transfer and arithmetic block.
// Assumes inclusion by the package and by the block itself.
`ifndef FPX_PARAMS_SVH
`define FPX_PARAMS_SVH
`define FPX_FP_STATUS_CTRL_REG_RST   32'h0000_0000
`define FPX_FLAG_HI     31
`define FPX_FLAG_LO     28
`define FPX_POP_MAX     5'h10
`define FPX_REG_SP      4'hd
`define FPX_REG_PC      4'hf
`define FPX_SGL_REBIAS  14'h0380
`define FPX_DBL_BIAS    14'h03ff
`define FPX_DBL_EMAX    14'h07ff
`define FPX_SGL_EMAX    14'h00ff
`endif

/* rtl/fpx_pkg.sv */
// Types shared by the floating-point transfer and arithmetic block.
// Assumes the constants header sits beside it.
`include "fpx_params.svh"
package fpx_pkg;
   typedef enum logic [3:0] {
      OP_MV_SCL, OP_MV_SGL, OP_MV_PAIR, OP_MV_DBL, OP_ST_RD, OP_ST_WR,
      OP_MUL, OP_NEG, OP_NMLA, OP_NMLS, OP_NMUL, OP_POP
   } fpx_op_e;
   // One issued instruction; to_core gives direction or status-read form
   typedef struct packed {
      fpx_op_e    op;
      logic       dp;
      logic       to_core;
      logic       half;
      logic [4:0] fd;
      logic [4:0] fn;
      logic [4:0] fm;
      logic [3:0] rt;
      logic [3:0] rt2;
      logic [4:0] cnt;
   } fpx_cmd_s;
   // Unpacked value, exponent on the double bias
   typedef struct packed {
      logic               s;
      logic signed [13:0] e;
      logic [52:0]        m;
   } fpx_unp_s;
   // Core register writeback, two ports
   typedef struct packed {
      logic        we0;
      logic [3:0]  idx0;
      logic [31:0] d0;
      logic        we1;
      logic [3:0]  idx1;
      logic [31:0] d1;
   } fpx_wb_s;
endpackage

/* rtl/fpx_core.sv */
// Floating-point register bank with core transfers, status register and arithmetic.
// Assumes the core pipeline evaluates conditions, reads core registers and
// feeds popped stack words in order; all inputs share CLK.
//
// Contract
// - Scalar read: half 0 low, 1 high.
// - Single move copies full word either way.
// - Pair move uses register and next register.
// - Doubleword move joins or splits two words.
// - Scalar write: half 0 low, 1 high.
// - Status read copies register to R0-R12 or R14.
// - Flag form copies comparison flags to NZCV.
// - Only flag form alters NZCV.
// - Status write loads register from core.
// - Multiply single or double, write product.
// - Negate inverts only the sign bit.
// - Negated accumulate: -d plus -product.
// - Negated subtract: -d plus product.
// - Negated multiply writes minus the product.
// - Pop loads 1 to 16 consecutive registers.
// - Other instructions leave flags unchanged.
// - Optional condition decides execution.
`timescale 1ns/100ps
`default_nettype none
`include "fpx_params.svh"
module fpx_core
   import fpx_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic        CMD_VALID,
   input  wire fpx_cmd_s    CMD,
   input  wire logic        COND_PASS,
   input  wire logic [31:0] CORE_RT,
   input  wire logic [31:0] CORE_RT2,
   input  wire logic        MEM_VALID,
   input  wire logic [31:0] MEM_DATA,
   output logic             CMD_READY,
   output logic             MEM_READY,
   output logic             CMD_ERR,
   output var fpx_wb_s      CORE_WB,
   output logic             FLAG_WE,
   output logic [3:0]       FLAG_NZCV,
   output logic [31:0]      STATUS_CTRL
);
   typedef enum {ST_IDLE, ST_POP} fpx_state_e;

   logic        rst_s1;
   logic        rst_n;
   logic [31:0] sreg [32];
   logic [31:0] fp_status_ctrl_reg;
   fpx_state_e  state;
   logic [4:0]  ptr;
   logic [5:0]  rem;

   // Unpack to a common double form; subnormals flush to zero
   function automatic fpx_unp_s unp(input logic [63:0] v, input logic dp);
      fpx_unp_s u;
      u.s = dp ? v[63] : v[31];
      u.e = dp ? {3'h0, v[62:52]} : {6'h00, v[30:23]} + `FPX_SGL_REBIAS;
      u.m = dp ? {1'b1, v[51:0]} : {1'b1, v[22:0], 29'h0};
      if ((dp && v[62:52] == 11'h000) || (!dp && v[30:23] == 8'h00)) begin
         u.e = 14'h0000;
         u.m = 53'h0;
      end
      return u;
   endfunction

   // Product keeps the top 53 bits; rounding is truncation
   function automatic fpx_unp_s mul(input fpx_unp_s a, input fpx_unp_s b);
      fpx_unp_s    r;
      logic [105:0] p;
      p   = a.m * b.m;
      r.s = a.s ^ b.s;
      r.e = a.e + b.e - `FPX_DBL_BIAS + (p[105] ? 14'h0001 : 14'h0000);
      r.m = p[105] ? p[105:53] : p[104:52];
      if (a.m == 53'h0 || b.m == 53'h0) begin
         r.e = 14'h0000;
         r.m = 53'h0;
      end
      return r;
   endfunction

   // Aligned add with leading-one normalisation
   function automatic fpx_unp_s add(input fpx_unp_s x, input fpx_unp_s y);
      fpx_unp_s    a;
      fpx_unp_s    b;
      fpx_unp_s    r;
      logic [13:0] d;
      logic [53:0] bm;
      logic [53:0] sm;
      logic [5:0]  lz;
      logic        found;
      a     = ({x.e, x.m} >= {y.e, y.m}) ? x : y;
      b     = ({x.e, x.m} >= {y.e, y.m}) ? y : x;
      d     = 14'(a.e - b.e);
      bm    = (d > 14'h0035) ? 54'h0 : ({1'b0, b.m} >> d);
      sm    = (a.s == b.s) ? {1'b0, a.m} + bm : {1'b0, a.m} - bm;
      lz    = 6'h00;
      found = 1'b0;
      for (int i = 52; i >= 0; i--) begin
         if (!found && sm[i]) begin
            lz    = 6'(52 - i);
            found = 1'b1;
         end
      end
      r.s = a.s;
      if (sm[53]) begin
         r.e = a.e + 14'h0001;
         r.m = sm[53:1];
      end else begin
         r.e = a.e - {8'h00, lz};
         r.m = 53'(sm << lz);
      end
      if (sm == 54'h0) begin
         r.e = 14'h0000;
         r.m = 53'h0;
      end
      return r;
   endfunction

   // Repack; underflow gives signed zero, overflow gives infinity
   function automatic logic [63:0] pack(input fpx_unp_s u, input logic dp);
      logic signed [13:0] es;
      es = dp ? u.e : u.e - `FPX_SGL_REBIAS;
      if (u.m == 53'h0 || es <= 0) begin
         pack = dp ? {u.s, 63'h0} : {32'h0, u.s, 31'h0};
      end else if (dp) begin
         pack = (es >= `FPX_DBL_EMAX) ? {u.s, 11'h7ff, 52'h0} : {u.s, es[10:0], u.m[51:0]};
      end else begin
         pack = (es >= `FPX_SGL_EMAX) ? {32'h0, u.s, 8'hff, 23'h0}
                                      : {32'h0, u.s, es[7:0], u.m[51:29]};
      end
   endfunction

   // Operand and move index decode
   wire         dp      = CMD.dp;
   wire [4:0]   sidx_n  = dp ? {CMD.fn[3:0], 1'b0} : CMD.fn;
   wire [4:0]   sidx_m  = dp ? {CMD.fm[3:0], 1'b0} : CMD.fm;
   wire [4:0]   sidx_d  = dp ? {CMD.fd[3:0], 1'b0} : CMD.fd;
   wire [63:0]  opn     = dp ? {sreg[{sidx_n[4:1], 1'b1}], sreg[sidx_n]} : {32'h0, sreg[sidx_n]};
   wire [63:0]  opm     = dp ? {sreg[{sidx_m[4:1], 1'b1}], sreg[sidx_m]} : {32'h0, sreg[sidx_m]};
   wire [63:0]  opd     = dp ? {sreg[{sidx_d[4:1], 1'b1}], sreg[sidx_d]} : {32'h0, sreg[sidx_d]};
   wire [63:0]  dn_val  = {sreg[{CMD.fn[3:0], 1'b1}], sreg[{CMD.fn[3:0], 1'b0}]};
   // Named slices for the checks, so that each history sample is a plain signal
   wire [31:0]  dn_lo   = dn_val[31:0];
   wire [31:0]  dn_hi   = dn_val[63:32];
   wire [31:0]  dn_keep = sreg[{CMD.fn[3:0], ~CMD.half}];
   wire [3:0]   st_flag = fp_status_ctrl_reg[`FPX_FLAG_HI:`FPX_FLAG_LO];
   wire [31:0]  n_word  = sreg[sidx_n];
   wire [31:0]  m_word  = sreg[sidx_m];
   wire         op_scl  = CMD.op == OP_MV_SCL;
   wire         op_dbl  = CMD.op == OP_MV_DBL;
   wire         op_pair = CMD.op == OP_MV_PAIR;
   wire         op_pop  = CMD.op == OP_POP;
   wire         is_mv   = op_scl || op_dbl || op_pair || CMD.op == OP_MV_SGL;
   wire         is_ar   = CMD.op inside {OP_MUL, OP_NEG, OP_NMLA, OP_NMLS, OP_NMUL};
   wire [4:0]   mv_idx0 = op_scl ? {CMD.fn[3:0], CMD.half}
                        : op_dbl ? {CMD.fn[3:0], 1'b0} : CMD.fn;
   wire [4:0]   mv_idx1 = op_dbl ? {CMD.fn[3:0], 1'b1} : 5'(CMD.fn + 5'h01);

   // Illegal rt outside doubleword moves, or illegal pop count, is refused and flagged
   wire chk_rt  = op_scl || op_pair || CMD.op == OP_MV_SGL || CMD.op == OP_ST_WR
                  || (CMD.op == OP_ST_RD && CMD.to_core);
   wire bad_rt  = chk_rt && (CMD.rt == `FPX_REG_PC || CMD.rt == `FPX_REG_SP);
   wire bad_cnt = op_pop && (CMD.cnt == 5'h00 || CMD.cnt > `FPX_POP_MAX);
   wire fire    = CMD_VALID && CMD_READY;
   wire go      = fire && COND_PASS && !bad_rt && !bad_cnt;

   // Arithmetic path, one cycle, product and accumulator negations applied in unpacked form
   fpx_unp_s ua, ub, ud, prod, nprod, nd;
   always_comb begin
      ua    = unp(opn, dp);
      ub    = unp(opm, dp);
      ud    = unp(opd, dp);
      prod  = mul(ua, ub);
      nprod = prod;
      nprod.s = ~prod.s;
      nd    = ud;
      nd.s  = ~ud.s;
   end
   wire [63:0] neg_v  = dp ? {~opm[63], opm[62:0]} : {32'h0, ~opm[31], opm[30:0]};
   wire [63:0] ar     = (CMD.op == OP_NEG)  ? neg_v
                      : (CMD.op == OP_NMUL) ? pack(nprod, dp)
                      : (CMD.op == OP_NMLA) ? pack(add(nd, nprod), dp)
                      : (CMD.op == OP_NMLS) ? pack(add(nd, prod), dp)
                      : pack(prod, dp);

   // Bank write ports; pop owns port 0 while the block is busy
   wire        pop_wr = state == ST_POP && MEM_VALID;
   wire        to_fp  = go && !CMD.to_core && is_mv;
   wire        we0    = pop_wr || (go && is_ar) || to_fp;
   wire [4:0]  idx0   = pop_wr ? ptr : is_ar ? sidx_d : mv_idx0;
   wire [31:0] d0     = pop_wr ? MEM_DATA : is_ar ? ar[31:0] : CORE_RT;
   wire        we1    = !pop_wr && go && ((is_ar && dp) || (to_fp && (op_pair || op_dbl)));
   wire [4:0]  idx1   = is_ar ? {sidx_d[4:1], 1'b1} : mv_idx1;
   wire [31:0] d1     = is_ar ? ar[63:32] : CORE_RT2;

   // Core writeback and flag transfer decode
   wire to_core  = go && CMD.to_core && (is_mv || CMD.op == OP_ST_RD);
   wire flag_set = go && CMD.op == OP_ST_RD && !CMD.to_core;
   fpx_wb_s next_wb;
   always_comb begin
      next_wb.we0  = to_core;
      next_wb.idx0 = CMD.rt;
      next_wb.d0   = (CMD.op == OP_ST_RD) ? fp_status_ctrl_reg : sreg[mv_idx0];
      next_wb.we1  = to_core && (op_pair || op_dbl);
      next_wb.idx1 = CMD.rt2;
      next_wb.d1   = sreg[mv_idx1];
   end

   assign CMD_READY   = state == ST_IDLE;
   assign MEM_READY   = state == ST_POP;
   assign STATUS_CTRL = fp_status_ctrl_reg;

   // Reset release through two flops
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // Register bank; untouched halves simply hold
   for (genvar i = 0; i < 32; i++) begin : g_reg
      always_ff @(posedge CLK or negedge rst_n) begin
         if (!rst_n) begin
            sreg[i] <= 32'h0;
         end else if (we0 && idx0 == 5'(i)) begin
            sreg[i] <= d0;
         end else if (we1 && idx1 == 5'(i)) begin
            sreg[i] <= d1;
         end
      end
   end

   // Status register and registered outputs
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         fp_status_ctrl_reg     <= `FPX_FP_STATUS_CTRL_REG_RST;
         CORE_WB   <= '0;
         FLAG_WE   <= 1'b0;
         FLAG_NZCV <= 4'h0;
         CMD_ERR   <= 1'b0;
      end else begin
         if (go && CMD.op == OP_ST_WR) begin
            fp_status_ctrl_reg <= CORE_RT;
         end
         CORE_WB   <= next_wb;
         FLAG_WE   <= flag_set;
         FLAG_NZCV <= fp_status_ctrl_reg[`FPX_FLAG_HI:`FPX_FLAG_LO];
         CMD_ERR   <= fire && (bad_rt || bad_cnt);
      end
   end

   // Pop sequencer: a double list is walked as pairs of words, low word first
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         ptr   <= 5'h00;
         rem   <= 6'h00;
      end else begin
         case (state)
            ST_IDLE: begin
               if (go && op_pop) begin
                  state <= ST_POP;
                  ptr   <= sidx_d;
                  rem   <= dp ? {CMD.cnt, 1'b0} : {1'b0, CMD.cnt};
               end
            end
            // One word per offered cycle; the last word frees the command port
            ST_POP: begin
               if (pop_wr) begin
                  ptr   <= 5'(ptr + 5'h01);
                  rem   <= 6'(rem - 6'h01);
                  state <= (rem == 6'h01) ? ST_IDLE : ST_POP;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_n);

   sequence s_scl_rd;
      go && op_scl && CMD.to_core;
   endsequence

   a_scalar_half_sel: assert property (s_scl_rd |=> CORE_WB.we0 &&
      CORE_WB.d0 == ($past(CMD.half) ? $past(dn_hi) : $past(dn_lo)))
      else $error("scalar read picked wrong half");
   a_single_move: assert property (go && CMD.op == OP_MV_SGL && !CMD.to_core |=>
      sreg[$past(CMD.fn)] == $past(CORE_RT))
      else $error("single move lost the word");
   a_pair_next: assert property (go && op_pair && !CMD.to_core |=>
      sreg[5'($past(CMD.fn) + 5'h01)] == $past(CORE_RT2))
      else $error("pair move missed next register");
   a_dword_join: assert property (go && op_dbl && !CMD.to_core |=>
      sreg[{$past(CMD.fn[3:0]), 1'b0}] == $past(CORE_RT)
      && sreg[{$past(CMD.fn[3:0]), 1'b1}] == $past(CORE_RT2))
      else $error("doubleword join wrong order");
   a_dword_split: assert property (go && op_dbl && CMD.to_core |=>
      CORE_WB.d0 == $past(dn_lo) && CORE_WB.d1 == $past(dn_hi))
      else $error("doubleword split wrong order");
   a_scalar_keep: assert property (go && op_scl && !CMD.to_core |=>
      sreg[{$past(CMD.fn[3:0]), ~$past(CMD.half)}]
      == $past(dn_keep))
      else $error("scalar write disturbed other half");
   a_flag_copy: assert property (flag_set |=> FLAG_WE &&
      FLAG_NZCV == $past(st_flag))
      else $error("flag transfer wrong");
   a_flags_kept: assert property (FLAG_WE |-> $past(go) &&
      $past(CMD.op) == OP_ST_RD && !$past(CMD.to_core))
      else $error("flags changed by another instruction");
   a_status_write: assert property (go && CMD.op == OP_ST_WR |=> fp_status_ctrl_reg == $past(CORE_RT))
      else $error("status write not loaded");
   a_status_read: assert property (go && CMD.op == OP_ST_RD && CMD.to_core |=>
      CORE_WB.we0 && CORE_WB.idx0 != `FPX_REG_PC && CORE_WB.d0 == $past(fp_status_ctrl_reg))
      else $error("status read wrong");
   a_cond_skip: assert property (fire && !COND_PASS |=> !CORE_WB.we0 && !FLAG_WE
      && $stable(fp_status_ctrl_reg) && CMD_READY)
      else $error("failed condition still executed");
   a_pop_busy: assert property (go && op_pop && !dp |=> !CMD_READY [*1] ##0
      rem == {1'b0, $past(CMD.cnt)})
      else $error("pop count not loaded");
   // Sign of a product follows the operand signs even for zero or overflow
   a_mul_sign: assert property (go && CMD.op == OP_MUL && !dp |=>
      ((sreg[$past(sidx_d)] ^ $past(n_word) ^ $past(m_word)) & 32'h8000_0000) == 32'h0)
      else $error("product sign wrong");
   a_nmul_sign: assert property (go && CMD.op == OP_NMUL && !dp |=>
      ((sreg[$past(sidx_d)] ^ $past(n_word) ^ $past(m_word)) & 32'h8000_0000) == 32'h8000_0000)
      else $error("negated product sign wrong");
   a_negate_sign: assert property (go && CMD.op == OP_NEG && !dp |=>
      sreg[$past(sidx_d)] == ($past(m_word) ^ 32'h8000_0000))
      else $error("negate changed more than the sign");
   a_refuse_operand: assert property (fire && bad_rt |=> CMD_ERR && !CORE_WB.we0
      && $stable(fp_status_ctrl_reg) && CMD_READY)
      else $error("refused operand still executed");
   a_pop_refuse: assert property (fire && bad_cnt |=> CMD_ERR && !MEM_READY)
      else $error("bad pop length accepted");
endmodule // fpx_core
`default_nettype wire

/* test/fpx_core_model.sv */
// Partner model: the integer core register file and the stack word source.
// Assumes the block's command, writeback and pop ports, all on CLK.
`timescale 1ns/100ps
`default_nettype none
module fpx_core_model
   import fpx_pkg::*;
(
   input  wire logic        CLK,
   input  wire fpx_cmd_s    CMD,
   input  wire fpx_wb_s     CORE_WB,
   input  wire logic        MEM_READY,
   output logic [31:0]      CORE_RT,
   output logic [31:0]      CORE_RT2,
   output logic             MEM_VALID,
   output logic [31:0]      MEM_DATA
);
   logic [31:0] regs [16];
   logic [31:0] stk [$];
   logic        slow;
   // Operand reads; callers name the pc or sp slots only for the refusal checks
   assign CORE_RT  = regs[CMD.rt];
   assign CORE_RT2 = regs[CMD.rt2];
   initial begin
      foreach (regs[i]) regs[i] = 32'h0;
      MEM_VALID = 1'b0;
      MEM_DATA = 32'h0;
      slow = 1'b0;
   end
   // Writebacks land here; a taken word is released with inverted data
   always @(posedge CLK) begin
      if (CORE_WB.we0) regs[CORE_WB.idx0] = CORE_WB.d0;
      if (CORE_WB.we1) regs[CORE_WB.idx1] = CORE_WB.d1;
      if (MEM_VALID && MEM_READY) begin
         void'(stk.pop_front());
         MEM_VALID <= 1'b0;
         MEM_DATA <= ~MEM_DATA;
      end
   end
   // Words in stack order, one offer every other cycle to show stalls;
   // the list always matches its size qualifier
   always @(negedge CLK) begin
      slow = ~slow;
      if (!MEM_VALID && MEM_READY && slow && stk.size() > 0) begin
         MEM_VALID <= 1'b1;
         MEM_DATA <= stk[0];
      end
   end
endmodule // fpx_core_model
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the floating-point transfer and arithmetic block.
// Assumes the package, the block and the core model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import fpx_pkg::*;
   logic        CLK, RST_B, CMD_VALID, COND_PASS, MEM_VALID;
   logic        CMD_READY, MEM_READY, CMD_ERR, FLAG_WE;
   logic [31:0] CORE_RT, CORE_RT2, MEM_DATA, STATUS_CTRL, lf, a, b, v;
   logic [3:0]  FLAG_NZCV;
   fpx_cmd_s    CMD;
   fpx_wb_s     CORE_WB;
   int          error_cnt, cmp_count, cyc, flag_seen, flag_exp, k;
   fpx_op_e     ops [4] = '{OP_MUL, OP_NMUL, OP_NMLA, OP_NMLS};
   logic [31:0] ex [4] = '{32'h40c0_0000, 32'hc0c0_0000, 32'hc0e0_0000, 32'h40a0_0000};

   fpx_core dut_u (.CLK(CLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD(CMD),
      .COND_PASS(COND_PASS), .CORE_RT(CORE_RT), .CORE_RT2(CORE_RT2),
      .MEM_VALID(MEM_VALID), .MEM_DATA(MEM_DATA), .CMD_READY(CMD_READY),
      .MEM_READY(MEM_READY), .CMD_ERR(CMD_ERR), .CORE_WB(CORE_WB),
      .FLAG_WE(FLAG_WE), .FLAG_NZCV(FLAG_NZCV), .STATUS_CTRL(STATUS_CTRL));
   fpx_core_model p_u (.CLK(CLK), .CMD(CMD), .CORE_WB(CORE_WB), .MEM_READY(MEM_READY),
      .CORE_RT(CORE_RT), .CORE_RT2(CORE_RT2), .MEM_VALID(MEM_VALID), .MEM_DATA(MEM_DATA));

   always #10 CLK = ~CLK;
   // Cycle ceiling and a count of flag pulses for the flag-only checks
   always @(posedge CLK) begin
      cyc++;
      if (FLAG_WE === 1'b1) flag_seen++;
      if (cyc > 4000) begin
         error_cnt++;
         wrap_up();
      end
   end

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic fpx_cmd_s mk(input fpx_op_e op, input logic dp, tc, h,
      input logic [4:0] d, n, m, input logic [3:0] t, t2, input logic [4:0] c);
      return {op, dp, tc, h, d, n, m, t, t2, c};
   endfunction
   task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
      cmp_count++;
      if (e !== g) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One command held over one taking edge; outputs settle by the next fall
   task automatic issue(input fpx_cmd_s c, input logic cp = 1'b1);
      @(negedge CLK);
      CMD_VALID = 1'b1;
      CMD = c;
      COND_PASS = cp;
      if (c.op == OP_ST_RD && !c.to_core && cp) flag_exp++;
      @(posedge CLK);
      @(negedge CLK);
      CMD_VALID = 1'b0;
   endtask
   task automatic wr_s(input logic [4:0] i, input logic [31:0] x, input logic cp = 1'b1);
      p_u.regs[2] = x;
      issue(mk(OP_MV_SGL, 1'b0, 1'b0, 1'b0, i, i, i, 4'h2, 4'h0, 5'h0), cp);
   endtask
   task automatic rd_s(input logic [4:0] i, output logic [31:0] x);
      issue(mk(OP_MV_SGL, 1'b0, 1'b1, 1'b0, i, i, i, 4'h1, 4'h0, 5'h0));
      x = CORE_WB.we0 ? CORE_WB.d0 : 32'hxxxx_xxxx;
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      CLK = 1'b0;
      RST_B = 1'b0;
      CMD_VALID = 1'b0;
      CMD = '0;
      COND_PASS = 1'b1;
      lf = 32'hf590;
      repeat (3) @(negedge CLK);
      RST_B = 1'b1;
      repeat (3) @(negedge CLK);
      chk("status_rst", 32'h0, STATUS_CTRL);
      chk("ready_rst", 1'b1, CMD_READY);
      // Random single moves, refused condition and sign flips
      for (int i = 0; i < 6; i++) begin
         lf = nxt(lf);
         a = lf;
         lf = nxt(lf);
         wr_s(a[4:0], a);
         wr_s(a[4:0], lf, 1'b0);
         rd_s(a[4:0], v);
         chk("single_move", a, v);
         issue(mk(OP_NEG, 1'b0, 1'b0, 1'b0, ~a[4:0], a[4:0], a[4:0], 4'h0, 4'h0, 5'h0));
         rd_s(~a[4:0], v);
         chk("negate", a ^ 32'h8000_0000, v);
      end
      $display("test moves done");
      // Doubleword join, scalar halves, scalar write keeps the other half
      a = nxt(lf);
      b = nxt(a);
      lf = b;
      p_u.regs[3] = a;
      p_u.regs[5] = b;
      issue(mk(OP_MV_DBL, 1'b1, 1'b0, 1'b0, 5'h7, 5'h7, 5'h7, 4'h3, 4'h5, 5'h0));
      for (int h = 0; h < 2; h++) begin
         issue(mk(OP_MV_SCL, 1'b1, 1'b1, h[0], 5'h7, 5'h7, 5'h7, 4'h1, 4'h0, 5'h0));
         chk("scalar_read", h ? b : a, CORE_WB.d0);
      end
      p_u.regs[2] = ~b;
      issue(mk(OP_MV_SCL, 1'b1, 1'b0, 1'b1, 5'h7, 5'h7, 5'h7, 4'h2, 4'h0, 5'h0));
      issue(mk(OP_MV_DBL, 1'b1, 1'b1, 1'b0, 5'h7, 5'h7, 5'h7, 4'h8, 4'h9, 5'h0));
      chk("dbl_split", {~b, a, 4'h8, 4'h9}, {CORE_WB.d1, CORE_WB.d0, CORE_WB.idx0, CORE_WB.idx1});
      issue(mk(OP_MV_PAIR, 1'b0, 1'b1, 1'b0, 5'he, 5'he, 5'he, 4'h6, 4'ha, 5'h0));
      chk("pair_read", {a, ~b}, {CORE_WB.d0, CORE_WB.d1});
      issue(mk(OP_MV_PAIR, 1'b0, 1'b0, 1'b0, 5'h1e, 5'h1e, 5'h1e, 4'h3, 4'h5, 5'h0));
      issue(mk(OP_MV_PAIR, 1'b0, 1'b1, 1'b0, 5'h1e, 5'h1e, 5'h1e, 4'h6, 4'ha, 5'h0));
      chk("pair_write", {a, b}, {CORE_WB.d0, CORE_WB.d1});
      $display("test double done");
      // Status register write, both read forms, refused pc and sp operands
      p_u.regs[4] = lf;
      issue(mk(OP_ST_WR, 1'b0, 1'b0, 1'b0, 5'h0, 5'h0, 5'h0, 4'h4, 4'h0, 5'h0));
      chk("status_wr", lf, STATUS_CTRL);
      issue(mk(OP_ST_RD, 1'b0, 1'b1, 1'b0, 5'h0, 5'h0, 5'h0, 4'he, 4'h0, 5'h0));
      chk("status_rd", {1'b1, lf}, {CORE_WB.we0, CORE_WB.d0});
      issue(mk(OP_ST_RD, 1'b0, 1'b0, 1'b0, 5'h0, 5'h0, 5'h0, 4'h0, 4'h0, 5'h0));
      chk("flags", {1'b1, lf[31:28]}, {FLAG_WE, FLAG_NZCV});
      issue(mk(OP_ST_WR, 1'b0, 1'b0, 1'b0, 5'h0, 5'h0, 5'h0, 4'hd, 4'h0, 5'h0));
      chk("sp_refused", {1'b1, lf}, {CMD_ERR, STATUS_CTRL});
      issue(mk(OP_MV_SGL, 1'b0, 1'b1, 1'b0, 5'h1, 5'h1, 5'h1, 4'hf, 4'h0, 5'h0));
      chk("pc_refused", 2'b10, {CMD_ERR, CORE_WB.we0});
      $display("test status done");
      // Exact single products and negated accumulates, then one double product
      wr_s(5'h0, 32'h4000_0000);
      wr_s(5'h1, 32'h4040_0000);
      for (int i = 0; i < 4; i++) begin
         wr_s(5'h3, 32'h3f80_0000);
         issue(mk(ops[i], 1'b0, 1'b0, 1'b0, 5'h3, 5'h0, 5'h1, 4'h0, 4'h0, 5'h0));
         rd_s(5'h3, v);
         chk("arith", ex[i], v);
      end
      p_u.regs[3] = 32'h0;
      p_u.regs[5] = 32'h4000_0000;
      p_u.regs[6] = 32'h4008_0000;
      issue(mk(OP_MV_DBL, 1'b1, 1'b0, 1'b0, 5'h4, 5'h4, 5'h4, 4'h3, 4'h5, 5'h0));
      issue(mk(OP_MV_DBL, 1'b1, 1'b0, 1'b0, 5'h5, 5'h5, 5'h5, 4'h3, 4'h6, 5'h0));
      issue(mk(OP_MUL, 1'b1, 1'b0, 1'b0, 5'h6, 5'h4, 5'h5, 4'h0, 4'h0, 5'h0));
      issue(mk(OP_MV_DBL, 1'b1, 1'b1, 1'b0, 5'h6, 5'h6, 5'h6, 4'h8, 4'h9, 5'h0));
      chk("dbl_mul", 64'h4018_0000_0000_0000, {CORE_WB.d1, CORE_WB.d0});
      $display("test arith done");
      // Stalled pops of singles and a double, then refused list lengths
      for (int p = 0; p < 2; p++) begin
         a = nxt(lf);
         b = nxt(a);
         lf = b;
         p_u.stk.push_back(a);
         p_u.stk.push_back(b);
         issue(mk(OP_POP, p[0], 1'b0, 1'b0, p ? 5'h8 : 5'h4, 5'h0, 5'h0, 4'h0, 4'h0,
            p ? 5'h1 : 5'h2));
         for (k = 0; k < 40 && MEM_READY !== 1'b0; k++) @(negedge CLK);
         chk("pop_end", 2'b01, {MEM_READY, CMD_READY});
         rd_s(p ? 5'h10 : 5'h4, v);
         chk("pop_lo", a, v);
         rd_s(p ? 5'h11 : 5'h5, v);
         chk("pop_hi", b, v);
      end
      for (int c = 0; c < 2; c++) begin
         issue(mk(OP_POP, 1'b0, 1'b0, 1'b0, 5'h0, 5'h0, 5'h0, 4'h0, 4'h0, c ? 5'h11 : 5'h0));
         chk("pop_refused", 2'b10, {CMD_ERR, MEM_READY});
      end
      chk("flag_pulses", flag_exp, flag_seen);
      $display("test pop done");
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
